// ==== hw/clk_gate_pkg.sv ====
// Offsets, field positions, reset values and types for the unit clock gate control
package clk_gate_pkg;

  localparam logic [11:0] DEEP_GATE_OFF   = 12'h120;
  localparam logic [11:0] RUN_GATE_OFF    = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFF  = 12'h110;
  localparam logic [11:0] RUN_CFG_OFF     = 12'h060;
  localparam logic [11:0] INT_STAT_OFF    = 12'h1f0;
  localparam logic [11:0] INT_MASK_OFF    = 12'h1f4;

  localparam logic [31:0] GATE_RESET      = 32'h00000040;
  localparam logic [31:0] RUN_CFG_RESET   = 32'h00000000;
  localparam logic [31:0] INT_RESET       = 32'h00000000;

  localparam int PWM_BIT         = 20;
  localparam int HIBERNATION_BIT = 6;
  localparam int WATCHDOG_BIT    = 3;
  localparam int AUTO_BIT        = 27;

  // Writable bits of every gating register; all others read zero
  localparam logic [31:0] GATE_MASK = 32'h00100048;
  localparam logic [31:0] CFG_MASK  = 32'h08000000;

  // Interrupt status bits
  localparam int EV_PWM_FAULT         = 0;
  localparam int EV_HIBERNATION_FAULT = 1;
  localparam int EV_WATCHDOG_FAULT    = 2;
  localparam int EV_BUS_ERR           = 3;
  localparam int NUM_EV               = 4;

  localparam int NUM_UNITS = 3;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_DEEP
  } pwr_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ERR1,
    PH_ERR2
  } err_phase_t;

endpackage

// ==== hw/unit_access_guard.sv ====
// Per-unit fault check on accesses to gated peripherals
`timescale 1ns/100ps
module unit_access_guard #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Unit access requests and clock enables
  input  wire logic [N-1:0] unit_req,
  input  wire logic [N-1:0] unit_clk_en,
  // Fault answers
  output logic      [N-1:0] unit_fault
);

  typedef struct packed {
    logic [N-1:0] fault;
  } guard_state_t;

  guard_state_t st_r;
  guard_state_t st_nxt;

  // Elaboration refuses an empty unit list
  if (N < 1) begin : g_bad_n
    $error("unit_access_guard needs at least one unit");
  end

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      st_nxt.fault[i] = unit_req[i] & ~unit_clk_en[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign unit_fault = st_r.fault;

endmodule

// ==== hw/clk_gate_ctrl.sv ====
// Unit clock gate control registers with AHB-Lite slave and interrupt
// How it works
// - Deep-sleep gating register at 0x120, resets to 0x00000040.
// - Bit 20 clocks the pulse-width modulator in deep-sleep; resets zero.
// - Bit 6 clocks the hibernation module in deep-sleep; resets one.
// - Bit 3 clocks the watchdog in deep-sleep; resets zero.
// - Access to a unit whose clock is gated off answers with a bus fault.
// - All other bits are read-only zero; software preserves them.
// - Run, sleep and deep-sleep each use their own gating register.
// - Sleep and deep-sleep registers apply only with auto gating select set.
`timescale 1ns/100ps
module clk_gate_ctrl
  import clk_gate_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state from the sleep controller
  input  wire clk_gate_pkg::pwr_mode_t pwr_mode,
  // Unit access requests: pulse-width modulator, hibernation, watchdog
  input  wire logic [clk_gate_pkg::NUM_UNITS-1:0] unit_req,
  // Unit clock enables and fault answers
  output logic [clk_gate_pkg::NUM_UNITS-1:0] unit_clk_en,
  output logic [clk_gate_pkg::NUM_UNITS-1:0] unit_fault,
  // Interrupt
  output logic             irq
);

  import clk_gate_pkg::*;

  typedef struct packed {
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] run_cfg;
    logic [NUM_EV-1:0] int_stat;
    logic [NUM_EV-1:0] int_mask;
    logic [NUM_UNITS-1:0] clk_en;
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    err_phase_t  err;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic        acc;
  logic        mapped;
  logic        bad_size;
  logic [31:0] sel_gate;
  logic [31:0] wmask;
  logic [NUM_EV-1:0] ev;
  logic [NUM_UNITS-1:0] fault_w;

  unit_access_guard #(
    .N (NUM_UNITS)
  ) u_guard (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .unit_req    (unit_req),
    .unit_clk_en (st_r.clk_en),
    .unit_fault  (fault_w)
  );

  assign acc      = hsel & hready & htrans[1];
  assign mapped   = (haddr == RUN_GATE_OFF) || (haddr == SLEEP_GATE_OFF) ||
                    (haddr == DEEP_GATE_OFF) || (haddr == RUN_CFG_OFF) ||
                    (haddr == INT_STAT_OFF) || (haddr == INT_MASK_OFF);
  // Only whole aligned words; anything else is an error, not a partial write
  assign bad_size = (hsize != 3'b010) || (haddr[1:0] != 2'b00);

  always_comb begin
    wmask = '0;
    unique case (st_r.wr_addr)
      RUN_GATE_OFF, SLEEP_GATE_OFF, DEEP_GATE_OFF: wmask = GATE_MASK;
      RUN_CFG_OFF: wmask = CFG_MASK;
      default: wmask = '0;
    endcase
  end

  // Select the governing register for the current power state
  always_comb begin
    sel_gate = st_r.run_gate;
    if (st_r.run_cfg[AUTO_BIT]) begin
      unique case (pwr_mode)
        PWR_RUN:   sel_gate = st_r.run_gate;
        PWR_SLEEP: sel_gate = st_r.sleep_gate;
        PWR_DEEP:  sel_gate = st_r.deep_gate;
        default:   sel_gate = st_r.run_gate;
      endcase
    end else begin
      sel_gate = st_r.run_gate;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_PWM_FAULT] = fault_w[0];
    ev[EV_HIBERNATION_FAULT] = fault_w[1];
    ev[EV_WATCHDOG_FAULT]    = fault_w[2];
    ev[EV_BUS_ERR]   = (st_r.err == PH_ERR1);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_en[0] = sel_gate[PWM_BIT];
    st_nxt.clk_en[1] = sel_gate[HIBERNATION_BIT];
    st_nxt.clk_en[2] = sel_gate[WATCHDOG_BIT];
    unique case (st_r.err)
      PH_ERR1: st_nxt.err = PH_ERR2;
      PH_ERR2: st_nxt.err = PH_IDLE;
      default: st_nxt.err = PH_IDLE;
    endcase
    st_nxt.wr_pend = 1'b0;
    // Data phase of a write lands here
    if (st_r.wr_pend) begin
      unique case (st_r.wr_addr)
        RUN_GATE_OFF:   st_nxt.run_gate   = hwdata & wmask;
        SLEEP_GATE_OFF: st_nxt.sleep_gate = hwdata & wmask;
        DEEP_GATE_OFF:  st_nxt.deep_gate  = hwdata & wmask;
        RUN_CFG_OFF:    st_nxt.run_cfg    = hwdata & wmask;
        INT_MASK_OFF:   st_nxt.int_mask   = hwdata[NUM_EV-1:0];
        INT_STAT_OFF:   st_nxt.int_stat   = st_r.int_stat & ~hwdata[NUM_EV-1:0];
        default:        st_nxt.run_cfg    = st_r.run_cfg;
      endcase
    end
    // New events win over a same-cycle clear
    st_nxt.int_stat = st_nxt.int_stat | ev;
    // Second error cycle shows hready high, so an address phase taken then is served
    if (acc && st_r.err != PH_ERR1) begin
      if (!mapped || bad_size) begin
        st_nxt.err = PH_ERR1;
      end else if (hwrite) begin
        st_nxt.wr_pend = 1'b1;
        st_nxt.wr_addr = haddr;
      end else begin
        unique case (haddr)
          RUN_GATE_OFF:   st_nxt.rdata = st_r.run_gate;
          SLEEP_GATE_OFF: st_nxt.rdata = st_r.sleep_gate;
          DEEP_GATE_OFF:  st_nxt.rdata = st_r.deep_gate;
          RUN_CFG_OFF:    st_nxt.rdata = st_r.run_cfg;
          INT_STAT_OFF:   st_nxt.rdata = {{(32-NUM_EV){1'b0}}, st_r.int_stat};
          INT_MASK_OFF:   st_nxt.rdata = {{(32-NUM_EV){1'b0}}, st_r.int_mask};
          default:        st_nxt.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.run_gate   <= GATE_RESET;
      st_r.sleep_gate <= GATE_RESET;
      st_r.deep_gate  <= GATE_RESET;
      st_r.run_cfg    <= RUN_CFG_RESET;
      st_r.int_stat   <= INT_RESET[NUM_EV-1:0];
      st_r.int_mask   <= INT_RESET[NUM_EV-1:0];
      st_r.clk_en     <= {GATE_RESET[WATCHDOG_BIT], GATE_RESET[HIBERNATION_BIT],
                          GATE_RESET[PWM_BIT]};
      st_r.wr_pend    <= 1'b0;
      st_r.wr_addr    <= '0;
      st_r.rdata      <= '0;
      st_r.err        <= PH_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Two-cycle error answer as the bus requires
  assign hreadyout   = (st_r.err != PH_ERR1);
  assign hresp       = (st_r.err != PH_IDLE);
  assign hrdata      = st_r.rdata;
  assign unit_clk_en = st_r.clk_en;
  assign unit_fault  = fault_w;
  assign irq         = |(st_r.int_stat & st_r.int_mask);

endmodule

// ==== test/clk_gate_ctrl_monitor.sv ====
// Port checker for the unit clock gate control
`timescale 1ns/100ps
module clk_gate_ctrl_monitor (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Units and interrupt
  input wire logic [2:0] unit_req,
  input wire logic [2:0] unit_clk_en,
  input wire logic [2:0] unit_fault,
  input wire logic       irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pwm_fault: assert property (unit_req[0] && !unit_clk_en[0] |=> unit_fault[0])
    else $error("pwm fault missing");
  a_hibernation_fault: assert property (unit_req[1] && !unit_clk_en[1] |=> unit_fault[1])
    else $error("hibernation fault missing");
  a_watchdog_fault: assert property (unit_req[2] && !unit_clk_en[2] |=> unit_fault[2])
    else $error("watchdog fault missing");
  a_fault_cause: assert property (|unit_fault |-> $past(|(unit_req & ~unit_clk_en)))
    else $error("fault without gated access");
  a_err_start: assert property ($rose(hresp) |-> !hreadyout)
    else $error("error start not waited");
  a_err_pair: assert property (!hreadyout |-> hresp ##1 (hresp && hreadyout))
    else $error("error answer not two cycles");
  a_rst_clk_en: assert property ($rose(hresetn) |-> unit_clk_en == 3'b010)
    else $error("reset clock enables wrong");
  a_rst_quiet: assert property ($rose(hresetn) |-> !irq && !hresp && hreadyout)
    else $error("reset outputs wrong");
  cover property (unit_fault == 3'b111);
  cover property ($rose(hresp));
  cover property ($rose(irq));
endmodule
bind clk_gate_ctrl clk_gate_ctrl_monitor mon (
  .hclk        (hclk),
  .hresetn     (hresetn),
  .hreadyout   (hreadyout),
  .hresp       (hresp),
  .unit_req    (unit_req),
  .unit_clk_en (unit_clk_en),
  .unit_fault  (unit_fault),
  .irq         (irq)
);

// ==== test/tb_top.sv ====
// Self-checking bench for the unit clock gate control
`timescale 1ns/100ps
module tb_top;
  import clk_gate_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        hready, hreadyout, hresp, irq, rs;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, unit_req = 0, unit_clk_en, unit_fault;
  logic [31:0] hwdata = 0, hrdata, rd;
  pwr_mode_t   pwr_mode = PWR_RUN;
  int          err_count = 0, n_checks = 0;
  assign hready = hreadyout;
  clk_gate_ctrl DUT (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .hrdata      (hrdata),
    .pwr_mode    (pwr_mode),
    .unit_req    (unit_req),
    .unit_clk_en (unit_clk_en),
    .unit_fault  (unit_fault),
    .irq         (irq)
  );
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(logic [31:0] g, logic [31:0] e, string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Sampling before the edge keeps the answer clear of that edge's updates
  task wt;
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge hclk);
      rd = hrdata;
      rs = hresp;
      if (hreadyout === 1'b1) break;
    end
    if (i == 20) begin
      chk(0, 1, "bus timeout");
      summarize();
    end
    @(posedge hclk);
  endtask
  task bus(logic [11:0] a, logic w, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  task rdc(logic [11:0] a, logic [31:0] e, string m);
    bus(a, 1'b0, 32'h0);
    chk(rd, e, m);
    chk(rs, 1'b0, m);
  endtask
  task en(logic [2:0] e, string m);
    @(posedge hclk);
    @(negedge hclk);
    chk(unit_clk_en, e, m);
  endtask
  task mode(pwr_mode_t m);
    @(posedge hclk);
    pwr_mode <= m;
  endtask
  task req(logic [2:0] e, string m);
    @(posedge hclk);
    unit_req <= 3'b111;
    @(posedge hclk);
    unit_req <= 3'b000;
    @(negedge hclk);
    chk(unit_fault, e, m);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(DEEP_GATE_OFF, GATE_RESET, "deep reset");
    rdc(RUN_GATE_OFF, GATE_RESET, "run reset");
    rdc(SLEEP_GATE_OFF, GATE_RESET, "sleep reset");
    rdc(RUN_CFG_OFF, 32'h0, "cfg reset");
    bus(DEEP_GATE_OFF, 1'b1, 32'hffffffff);
    rdc(DEEP_GATE_OFF, GATE_MASK, "reserved bits");
    $display("test registers done");
    mode(PWR_DEEP);
    en(3'b010, "run governs deep");
    bus(RUN_CFG_OFF, 1'b1, CFG_MASK);
    en(3'b111, "deep governs");
    mode(PWR_SLEEP);
    en(3'b010, "sleep governs");
    mode(PWR_DEEP);
    bus(DEEP_GATE_OFF, 1'b1, 32'h0);
    en(3'b000, "all gated");
    $display("test modes done");
    bus(INT_MASK_OFF, 1'b1, 32'hf);
    req(3'b111, "gated fault");
    @(negedge hclk);
    chk(irq, 1'b1, "irq raised");
    bus(INT_MASK_OFF, 1'b1, 32'h0);
    @(negedge hclk);
    chk(irq, 1'b0, "irq masked");
    rdc(INT_STAT_OFF, 32'h7, "fault status");
    bus(INT_STAT_OFF, 1'b1, 32'h7);
    rdc(INT_STAT_OFF, 32'h0, "status cleared");
    bus(DEEP_GATE_OFF, 1'b1, GATE_MASK);
    req(3'b000, "clocked no fault");
    $display("test faults done");
    bus(12'h004, 1'b0, 32'h0);
    chk(rs, 1'b1, "unmapped error");
    hsize <= 3'h0;
    bus(DEEP_GATE_OFF, 1'b1, 32'h0);
    chk(rs, 1'b1, "size error");
    hsize <= 3'h2;
    rdc(DEEP_GATE_OFF, GATE_MASK, "size error no write");
    rdc(INT_STAT_OFF, 32'h8, "bus error status");
    $display("test unmapped done");
    summarize();
  end
endmodule
